// ==== sim/dmast_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module dmast_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire dmast_pkg::dmast_bus_s bus,
  input wire dmast_pkg::dmast_eng_s eng,
  input wire dmast_pkg::dmast_cpu_s cpu,
  input wire logic [15:0] rdata,
  input wire logic [7:0] pingpong_buffer_indicator,
  input wire logic irq
);
  import dmast_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire rd_act = bus.rd && bus.addr == OFF_ACTIVITY;
  wire rd_adr = bus.rd && bus.addr == OFF_RECENT_ADDR;
  wire rd_col = bus.rd && bus.addr == OFF_COLLISION;
  AST_TOP_ZERO: assert property (rd_act |=> rdata[15:12] == 4'h0)
    else $error("activity top bits not zero");
  AST_CODE_LEGAL: assert property (rd_act |=> rdata[11:8] <= 4'h7 || rdata[11:8] == 4'hF)
    else $error("reserved last channel code");
  AST_PP_READ: assert property (rd_act |=> rdata[7:0] == $past(pingpong_buffer_indicator))
    else $error("indicator read mismatch");
  AST_LAST_CH: assert property (eng.xfer_done == 8'h20 ##1 !eng.xfer_done[*2] ##0 rd_act
    |=> rdata[11:8] == 4'h5) else $error("last channel not 5");
  AST_PP_HOLD: assert property (!eng.ch_mode[1] |=> !pingpong_buffer_indicator[0])
    else $error("indicator set outside ping-pong");
  AST_PP_TOGGLE: assert property (eng.ch_mode[1] && eng.block_done[0]
    |=> pingpong_buffer_indicator[0] != $past(pingpong_buffer_indicator[0]))
    else $error("indicator did not toggle");
  AST_ADDR: assert property (eng.ram_access == 8'h01 ##1 !eng.ram_access[*2] ##0 rd_adr
    |=> rdata == $past(eng.ram_addr, 3)) else $error("recent address mismatch");
  AST_COLL: assert property (eng.dma_ram_wr == 8'h04 && cpu.cpu_ram_wr &&
    eng.dma_wr_addr == cpu.cpu_wr_addr ##1 !bus.wr ##1 rd_col |=> rdata[2])
    else $error("ram collision flag not set");
endmodule : dmast_chk
`default_nettype wire

// ==== sim/dmast_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// cpu writer; address shows a changing pattern when no write is made
module dmast_cpu_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [1:0] kind,
  input wire logic [15:0] addr,
  output var dmast_pkg::dmast_cpu_s cpu
);
  import dmast_pkg::*;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cpu <= '0;
    end else begin
      cpu.cpu_periph_wr <= kind[1];
      cpu.cpu_ram_wr <= kind[0];
      cpu.cpu_wr_addr <= (kind != 2'h0) ? addr : ~cpu.cpu_wr_addr;
    end
  end
endmodule : dmast_cpu_model
`default_nettype wire

// ==== sim/dmast_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dmast_pkg::*;
  logic core_clk, rst, irq;
  dmast_bus_s bus;
  dmast_eng_s eng, e;
  dmast_cpu_s cpu;
  logic [15:0] rdata, caddr;
  logic [7:0] ppi;
  logic [1:0] kind;
  int n_fail, comparisons;
  dmast_status i_dut (.core_clk(core_clk), .rst(rst), .bus(bus), .eng(eng), .cpu(cpu),
    .rdata(rdata), .pingpong_buffer_indicator(ppi), .irq(irq));
  dmast_cpu_model i_cpu (.core_clk(core_clk), .rst(rst), .kind(kind), .addr(caddr), .cpu(cpu));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic acc(logic w, logic [3:0] a, logic [15:0] d);
    @(posedge core_clk);
    bus <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge core_clk);
    bus <= '0;
    #1;
  endtask : acc
  task automatic rd(logic [3:0] a, logic [15:0] exp);
    acc(1'b0, a, 16'h0000);
    check("rdata", rdata, exp);
  endtask : rd
  task automatic pulse(dmast_eng_s v);
    dmast_eng_s h;
    h = '0;
    h.ch_mode = v.ch_mode;
    @(posedge core_clk);
    eng <= v;
    kind <= 2'h0;
    @(posedge core_clk);
    eng <= h;
  endtask : pulse
  task automatic coll(logic [1:0] k, dmast_eng_s v);
    @(posedge core_clk);
    kind <= k;
    caddr <= 16'h0100;
    pulse(v);
  endtask : coll
  initial begin
    repeat (5000) @(posedge core_clk);
    n_fail++;
    complete_run();
  end
  initial begin
    rst = 1'b1;
    bus = '0;
    eng = '0;
    kind = 2'h0;
    caddr = 16'h0000;
    n_fail = 0;
    comparisons = 0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    rd(OFF_COLLISION, 16'h0000);
    rd(OFF_ACTIVITY, 16'h0F00);
    rd(OFF_RECENT_ADDR, ADDR_RESET);
    for (int i = 0; i < 8; i++) begin
      e = '0;
      e.xfer_done = 8'h01 << i;
      pulse(e);
      rd(OFF_ACTIVITY, {4'h0, i[3:0], 8'h00});
    end
    rd(OFF_IRQ_STATUS, 16'h0004);
    check("irq", {15'h0, irq}, 16'h0000);
    acc(1'b1, OFF_IRQ_ENABLE, 16'h0004);
    rd(OFF_IRQ_ENABLE, 16'h0004);
    check("irq", {15'h0, irq}, 16'h0001);
    acc(1'b1, OFF_IRQ_CLEAR, 16'h000F);
    rd(OFF_IRQ_STATUS, 16'h0000);
    check("irq", {15'h0, irq}, 16'h0000);
    acc(1'b1, OFF_ACTIVITY, 16'hFFFF);
    rd(OFF_ACTIVITY, 16'h0700);
    rd(4'hF, 16'h0000);
    rd(OFF_RECENT_ADDR, ADDR_RESET);
    @(posedge core_clk);
    #1 check("rdata idle", rdata, 16'h0000);
    e = '0;
    e.ram_access = 8'h01;
    e.ram_addr = 16'hA5C3;
    pulse(e);
    rd(OFF_RECENT_ADDR, 16'hA5C3);
    e = '0;
    e.dma_wr_addr = 16'h0100;
    e.dma_ram_wr = 8'h04;
    coll(2'h1, e);
    rd(OFF_COLLISION, 16'h0004);
    e.dma_ram_wr = 8'h00;
    e.dma_periph_wr = 8'h80;
    coll(2'h2, e);
    e.dma_periph_wr = 8'h01;
    e.dma_wr_addr = 16'h0101;
    coll(2'h2, e);
    rd(OFF_COLLISION, 16'h8004);
    acc(1'b1, OFF_COLLISION, 16'h7FFF);
    rd(OFF_COLLISION, 16'h8000);
    acc(1'b1, OFF_COLLISION, 16'hFFFF);
    rd(OFF_COLLISION, 16'h0000);
    e = '0;
    e.ch_mode = {10'h000, 2'h1, MODE_PP_ONESHOT, MODE_PP_CONT};
    e.block_done = 8'h07;
    pulse(e);
    #1 check("ppi", {8'h00, ppi}, 16'h0003);
    rd(OFF_ACTIVITY, 16'h0703);
    pulse(e);
    #1 check("ppi", {8'h00, ppi}, 16'h0000);
    pulse(e);
    e.ch_mode = 16'h0000;
    pulse(e);
    #1 check("ppi", {8'h00, ppi}, 16'h0000);
    rd(OFF_IRQ_STATUS, 16'h000B);
    check("irq", {15'h0, irq}, 16'h0000);
    complete_run();
  end
endmodule : testbench
bind dmast_status dmast_chk i_chk (.core_clk(core_clk), .rst(rst), .bus(bus), .eng(eng),
  .cpu(cpu), .rdata(rdata), .pingpong_buffer_indicator(pingpong_buffer_indicator), .irq(irq));
`default_nettype wire

// ==== verilog/dmast_chan_sel.sv ====
`timescale 1ns/1ps
`default_nettype none
// picks the lowest channel with a pulse and encodes it
module dmast_chan_sel #(
  parameter int unsigned N = 8
) (
  input wire logic [N-1:0] req,
  output logic any,
  output logic [3:0] idx
);
  initial begin
    if (N > 8 || N < 1) $error("dmast_chan_sel: N must be 1..8");
  end

  always_comb begin
    any = 1'b0;
    idx = 4'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = 4'(i);
      end
    end
  end
endmodule : dmast_chan_sel
`default_nettype wire

// ==== verilog/dmast_pkg.sv ====
`default_nettype none
package dmast_pkg;
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned REG_W = 16;
  localparam int unsigned ADDR_W = 4;

  // register map, word index on the plain register port
  localparam logic [3:0] OFF_COLLISION = 4'h0;
  localparam logic [3:0] OFF_ACTIVITY = 4'h1;
  localparam logic [3:0] OFF_RECENT_ADDR = 4'h2;
  localparam logic [3:0] OFF_IRQ_STATUS = 4'h3;
  localparam logic [3:0] OFF_IRQ_ENABLE = 4'h4;
  localparam logic [3:0] OFF_IRQ_CLEAR = 4'h5;

  // field positions
  localparam int unsigned PERIPH_WRITE_COLLISION_FLAG_LSB = 8;
  localparam int unsigned RAM_WRITE_COLLISION_FLAG_LSB = 0;
  localparam int unsigned LAST_CH_LSB = 8;
  localparam int unsigned PPIND_LSB = 0;

  localparam logic [3:0] LAST_CH_NONE = 4'hF;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [1:0] MODE_PP_CONT = 2'h2;
  localparam logic [1:0] MODE_PP_ONESHOT = 2'h3;

  // interrupt status bits
  localparam int unsigned IRQ_PCOL = 0;
  localparam int unsigned IRQ_XCOL = 1;
  localparam int unsigned IRQ_XFER = 2;
  localparam int unsigned IRQ_BLOCK = 3;
  localparam int unsigned IRQ_W = 4;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [15:0] wdata;
  } dmast_bus_s;

  // per-channel engine activity, one cycle pulses except mode
  typedef struct packed {
    logic [7:0] xfer_done;
    logic [7:0] block_done;
    logic [15:0] ch_mode;
    logic [7:0] dma_periph_wr;
    logic [7:0] dma_ram_wr;
    logic [15:0] dma_wr_addr;
    logic [7:0] ram_access;
    logic [15:0] ram_addr;
  } dmast_eng_s;

  typedef struct packed {
    logic cpu_periph_wr;
    logic cpu_ram_wr;
    logic [15:0] cpu_wr_addr;
  } dmast_cpu_s;
endpackage : dmast_pkg
`default_nettype wire

// ==== verilog/dmast_status.sv ====
// What this block does
// - per-channel peripheral collision flags, bits 15..8
// - per-channel RAM collision flags, bits 7..0
// - flags reset zero, set on collision, software clears
// - last channel reads 1111 until first transfer
// - last channel loads number of transferring channel
// - ping-pong bit: one means secondary buffer
// - activity register read-only, top four bits zero
// - recent RAM address, resets zero, every access
// - ping-pong enabled for mode codes 10, 11
`timescale 1ns/1ps
`default_nettype none
module dmast_status #(
  parameter int unsigned NUM_CH = dmast_pkg::NUM_CH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire dmast_pkg::dmast_bus_s bus,
  input wire dmast_pkg::dmast_eng_s eng,
  input wire dmast_pkg::dmast_cpu_s cpu,
  output logic [15:0] rdata,
  output logic [7:0] pingpong_buffer_indicator,
  output logic irq
);
  import dmast_pkg::*;

  initial begin
    if (NUM_CH != dmast_pkg::NUM_CH) $error("dmast_status: only eight channels served");
  end

  logic [7:0] periph_write_collision_flag;
  logic [7:0] ram_write_collision_flag;
  logic [3:0] last_active_channel;
  logic [15:0] recent_ram_address;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_enable;
  logic [7:0] pcol_hit;
  logic [7:0] xcol_hit;
  logic [7:0] pp_enabled;
  logic xfer_any;
  logic [3:0] xfer_idx;
  logic ram_any;
  logic [3:0] ram_idx;
  logic [15:0] next_rdata;

  function automatic logic pp_mode(input logic [1:0] m);
    return (m == MODE_PP_CONT) || (m == MODE_PP_ONESHOT);
  endfunction : pp_mode

  function automatic logic wr_to(input logic [3:0] off);
    return bus.wr && (bus.addr == off);
  endfunction : wr_to

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pcol_hit[i] = eng.dma_periph_wr[i] && cpu.cpu_periph_wr &&
                    (eng.dma_wr_addr == cpu.cpu_wr_addr);
      xcol_hit[i] = eng.dma_ram_wr[i] && cpu.cpu_ram_wr &&
                    (eng.dma_wr_addr == cpu.cpu_wr_addr);
      pp_enabled[i] = pp_mode(eng.ch_mode[2*i +: 2]);
    end
  end

  dmast_chan_sel #(.N(8)) u_xfer_sel (
    .req(eng.xfer_done),
    .any(xfer_any),
    .idx(xfer_idx)
  );

  dmast_chan_sel #(.N(8)) u_ram_sel (
    .req(eng.ram_access),
    .any(ram_any),
    .idx(ram_idx)
  );

  // collision flags: a set in the clearing cycle wins
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      periph_write_collision_flag <= 8'h00;
      ram_write_collision_flag <= 8'h00;
    end else begin
      if (wr_to(OFF_COLLISION)) begin
        // writing one clears, writing zero leaves; no write can set
        periph_write_collision_flag <= (periph_write_collision_flag &
          ~bus.wdata[PERIPH_WRITE_COLLISION_FLAG_LSB +: 8]) | pcol_hit;
        ram_write_collision_flag <= (ram_write_collision_flag &
          ~bus.wdata[RAM_WRITE_COLLISION_FLAG_LSB +: 8]) | xcol_hit;
      end else begin
        periph_write_collision_flag <= periph_write_collision_flag | pcol_hit;
        ram_write_collision_flag <= ram_write_collision_flag | xcol_hit;
      end
    end
  end

  // only codes 0..7 or the reset code are ever loaded
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      last_active_channel <= LAST_CH_NONE;
    end else if (xfer_any) begin
      last_active_channel <= xfer_idx;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pingpong_buffer_indicator <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (!pp_enabled[i]) begin
          pingpong_buffer_indicator[i] <= 1'b0;
        end else if (eng.block_done[i]) begin
          pingpong_buffer_indicator[i] <= ~pingpong_buffer_indicator[i];
        end
      end
    end
  end

  // ram_idx encodes the lowest accessing channel but is unused; any access loads the shared ram_addr
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      recent_ram_address <= ADDR_RESET;
    end else if (ram_any) begin
      recent_ram_address <= eng.ram_addr;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_enable <= '0;
    end else if (wr_to(OFF_IRQ_ENABLE)) begin
      irq_enable <= bus.wdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_status <= '0;
    end else begin
      logic [IRQ_W-1:0] ev;
      logic [IRQ_W-1:0] clr;
      ev = '0;
      ev[IRQ_PCOL] = |pcol_hit;
      ev[IRQ_XCOL] = |xcol_hit;
      ev[IRQ_XFER] = xfer_any;
      ev[IRQ_BLOCK] = |eng.block_done;
      clr = wr_to(OFF_IRQ_CLEAR) ? bus.wdata[IRQ_W-1:0] : '0;
      irq_status <= (irq_status & ~clr) | ev;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end

  always_comb begin
    next_rdata = 16'h0000;
    if (bus.rd) begin
      case (bus.addr)
        OFF_COLLISION: begin
          next_rdata[PERIPH_WRITE_COLLISION_FLAG_LSB +: 8] = periph_write_collision_flag;
          next_rdata[RAM_WRITE_COLLISION_FLAG_LSB +: 8] = ram_write_collision_flag;
        end
        OFF_ACTIVITY: begin
          // bits 15..12 stay zero, writes here are ignored
          next_rdata[LAST_CH_LSB +: 4] = last_active_channel;
          next_rdata[PPIND_LSB +: 8] = pingpong_buffer_indicator;
        end
        OFF_RECENT_ADDR: next_rdata = recent_ram_address;
        OFF_IRQ_STATUS: next_rdata[IRQ_W-1:0] = irq_status;
        OFF_IRQ_ENABLE: next_rdata[IRQ_W-1:0] = irq_enable;
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= next_rdata;
    end
  end
endmodule : dmast_status
`default_nettype wire
